// ==== rtl/acfm_top.v ====
// Converter control registers, input current result and fault interrupt masking.
//
// Behaviour
// - Mask bit 7 gates input fault interrupt.
// - Mask bit 6 gates battery fault interrupts.
// - Mask bit 5 gates system fault interrupts.
// - Mask bit 3 gates thermal shutdown interrupt.
// - Mask bit 0 gates temperature zone interrupt.
// - Control bit 7 enables converter, default off.
// - Results reset zero, then hold last value.
// - Control bit 6: continuous or single shot.
// - Bits 5:4 pick resolution, default three.
// - Control bit 3 selects running average reporting.
// - Control bit 2 picks running average seed.
// - One disable bit per measured channel.
// - Input current in bits 15:1, two's complement.
// - Input current clamps to plus minus 2000.
// - Single shot completion pulses unless masked.
// - Input fault flag set on entry, unmasked.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "acfm_defs.vh"

module acfm_top (
  // Clock, reset and clock enable.
  input wire ref_clk,
  input wire reset_n,
  input wire clk_en,
  // Avalon-MM slave.
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Asynchronous fault comparators.
  input wire input_fault_in,
  input wire battery_ocp_in,
  input wire battery_ovp_in,
  input wire system_ovp_in,
  input wire system_short_in,
  input wire thermal_shutdown_in,
  input wire [2:0] temp_zone_in,
  // Converter front end, same clock.
  input wire conv_done,
  input wire [15:0] conv_iin_raw,
  // Converter settings.
  output reg conv_enable,
  output reg conv_single_shot,
  output reg [1:0] conv_resolution,
  output reg running_average_sel,
  output reg average_seed_sel,
  output reg [7:0] conv_channel_off,
  // Shared interrupt pulse.
  output reg irq_pulse
);

  // ---------------------------------------------------------------
  // Register state.
  // ---------------------------------------------------------------
  // Fault interrupt mask, reserved bits held at zero.
  reg [7:0] fault_irq_mask_q;
  // Conversion done mask, only bit 6 is kept.
  reg [7:0] done_mask_q;
  // Input current result field, bits 15:1 of the register.
  reg [14:0] input_current_value_q;
  // Sticky input fault flag.
  reg input_fault_flag_q;
  // Running average has its seed.
  reg avg_primed_q;

  // ---------------------------------------------------------------
  // Fault input synchronisation and event detection.
  // ---------------------------------------------------------------
  // Comparators come from the analog side, so they pass two flops first.
  wire [6:0] fault_raw;
  wire [6:0] fault_sync;
  wire [6:0] fault_rise;
  wire [2:0] zone_sync;
  wire zone_change;
  assign fault_raw = {input_fault_in, battery_ocp_in, battery_ovp_in, system_ovp_in,
                      system_short_in, thermal_shutdown_in, 1'b0};
  acfm_sync #(.W(7)) u_fault_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in(fault_raw),
    .sync_out(fault_sync)
  );

  acfm_event #(.W(7)) u_fault_event (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .level_in(fault_sync),
    .rise(fault_rise),
    .change()
  );

  // The zone code may settle over two bits in different cycles; that shows as
  // two changes, which costs at most one extra pulse.
  acfm_sync #(.W(3)) u_zone_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in(temp_zone_in),
    .sync_out(zone_sync)
  );

  acfm_event #(.W(3)) u_zone_event (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .level_in(zone_sync),
    .rise(),
    .change(zone_change)
  );

  // ---------------------------------------------------------------
  // Bus decode.
  // ---------------------------------------------------------------
  // A request is answered when waitrequest is low; that edge is the only one
  // at which writes land and read side effects happen.
  wire [5:0] reg_idx;
  wire bus_req;
  wire bus_accept;
  wire wr_lane0;
  wire wr_fault_mask;
  wire wr_conv_ctrl;
  wire wr_ch_disable;
  wire wr_done_mask;
  wire rd_fault_flag;
  assign reg_idx = avs_address[7:2];
  assign bus_req = avs_read | avs_write;
  assign bus_accept = bus_req & (avs_waitrequest == `ACFM_WAIT_DONE);
  assign wr_lane0 = bus_accept & avs_write & avs_byteenable[0];
  assign wr_fault_mask = wr_lane0 & (reg_idx == `ACFM_IDX_FAULT_MASK);
  assign wr_conv_ctrl = wr_lane0 & (reg_idx == `ACFM_IDX_CONV_CTRL);
  assign wr_ch_disable = wr_lane0 & (reg_idx == `ACFM_IDX_CH_DISABLE);
  assign wr_done_mask = wr_lane0 & (reg_idx == `ACFM_IDX_DONE_MASK);
  assign rd_fault_flag = bus_accept & avs_read & (reg_idx == `ACFM_IDX_FAULT_FLAG);

  // ---------------------------------------------------------------
  // Read multiplexer.
  // ---------------------------------------------------------------
  // Unmapped indices and reserved bits read as zero.
  reg [31:0] rd_data;
  always @* begin
    rd_data = 32'h00000000;
    case (reg_idx)
      `ACFM_IDX_FAULT_FLAG: begin
        rd_data[`ACFM_BIT_INPUT_FLAG] = input_fault_flag_q;
      end
      `ACFM_IDX_DONE_MASK: begin
        rd_data[7:0] = done_mask_q;
      end
      `ACFM_IDX_FAULT_MASK: begin
        rd_data[7:0] = fault_irq_mask_q;
      end
      `ACFM_IDX_CONV_CTRL: begin
        rd_data[7:0] = {conv_enable, conv_single_shot, conv_resolution,
                        running_average_sel, average_seed_sel, 2'b00};
      end
      `ACFM_IDX_CH_DISABLE: begin
        rd_data[7:0] = conv_channel_off;
      end
      `ACFM_IDX_IIN_RESULT: begin
        rd_data[15:0] = {input_current_value_q, 1'b0};
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Bus handshake.
  // ---------------------------------------------------------------
  // Fixed one wait cycle: read data is registered before waitrequest drops,
  // which keeps the decode path out of the master's sampling edge.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= `ACFM_WAIT_BUSY;
      avs_readdata <= 32'h00000000;
    end else if (clk_en) begin
      if (bus_req && (avs_waitrequest == `ACFM_WAIT_BUSY)) begin
        avs_waitrequest <= `ACFM_WAIT_DONE;
        avs_readdata <= avs_read ? rd_data : 32'h00000000;
      end else begin
        avs_waitrequest <= `ACFM_WAIT_BUSY;
      end
    end
  end

  // ---------------------------------------------------------------
  // Result arithmetic.
  // ---------------------------------------------------------------
  // Clamp the raw code, then optionally average with the held value.
  wire signed [15:0] raw_s;
  wire signed [15:0] held_s;
  reg signed [15:0] clamped_s;
  reg signed [15:0] sum_s;
  reg [14:0] next_value;
  assign raw_s = conv_iin_raw;
  assign held_s = {input_current_value_q[14], input_current_value_q};
  always @* begin
    if (raw_s > `ACFM_IIN_MAX) begin
      clamped_s = `ACFM_IIN_MAX;
    end else if (raw_s < `ACFM_IIN_MIN) begin
      clamped_s = `ACFM_IIN_MIN;
    end else begin
      clamped_s = raw_s;
    end
    // Both terms lie within the clamp, so the sum cannot overflow 16 bits.
    sum_s = clamped_s + held_s;
    if (!running_average_sel) begin
      next_value = clamped_s[14:0];
    end else if (!avg_primed_q && average_seed_sel) begin
      next_value = clamped_s[14:0];
    end else begin
      next_value = sum_s[15:1];
    end
  end

  // Conversion results are taken only while the converter runs.
  wire result_take;
  wire conv_finished;
  assign conv_finished = conv_done & conv_enable;
  assign result_take = conv_finished & ~conv_channel_off[`ACFM_BIT_IIN_CH_OFF];

  // ---------------------------------------------------------------
  // Control registers.
  // ---------------------------------------------------------------
  // A single shot ends by clearing the enable; a control write in the same cycle wins
  // because software asked for it last.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_irq_mask_q <= `ACFM_RST_FAULT_MASK;
      done_mask_q <= `ACFM_RST_DONE_MASK;
      conv_enable <= `ACFM_RST_CONV_EN;
      conv_single_shot <= `ACFM_RST_SINGLE_SHOT;
      conv_resolution <= `ACFM_RST_RESOLUTION;
      running_average_sel <= `ACFM_RST_AVG_SEL;
      average_seed_sel <= `ACFM_RST_SEED_SEL;
      conv_channel_off <= `ACFM_RST_CH_DISABLE;
    end else if (clk_en) begin
      if (wr_fault_mask) begin
        fault_irq_mask_q <= avs_writedata[7:0] & `ACFM_WMASK_FAULT_MASK;
      end
      if (wr_done_mask) begin
        done_mask_q <= avs_writedata[7:0] & `ACFM_WMASK_DONE_MASK;
      end
      if (wr_conv_ctrl) begin
        conv_enable <= avs_writedata[`ACFM_BIT_CONV_EN];
        conv_single_shot <= avs_writedata[`ACFM_BIT_SINGLE_SHOT];
        conv_resolution <= avs_writedata[`ACFM_BIT_RES_HI:`ACFM_BIT_RES_LO];
        running_average_sel <= avs_writedata[`ACFM_BIT_AVG_SEL];
        average_seed_sel <= avs_writedata[`ACFM_BIT_SEED_SEL];
      end else if (conv_finished && conv_single_shot) begin
        conv_enable <= 1'b0;
      end
      if (wr_ch_disable) begin
        conv_channel_off <= avs_writedata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Result register and averaging seed.
  // ---------------------------------------------------------------
  // The result never clears itself; disabling only stops updates.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      input_current_value_q <= `ACFM_RST_RESULT;
      avg_primed_q <= 1'b0;
    end else if (clk_en) begin
      if (result_take) begin
        input_current_value_q <= next_value;
      end
      // Re-seed whenever averaging or the converter is switched off.
      if (!running_average_sel || !conv_enable) begin
        avg_primed_q <= 1'b0;
      end else if (result_take) begin
        avg_primed_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Input fault flag.
  // ---------------------------------------------------------------
  // Cleared by reading it; an entry in the read cycle keeps it set.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      input_fault_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (fault_rise[6]) begin
        input_fault_flag_q <= 1'b1;
      end else if (rd_fault_flag) begin
        input_fault_flag_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt combining.
  // ---------------------------------------------------------------
  // Masks gate only the pulse, never the flag or the result.
  wire ev_input;
  wire ev_battery;
  wire ev_system;
  wire ev_thermal;
  wire ev_zone;
  wire ev_done;
  assign ev_input = fault_rise[6] & ~fault_irq_mask_q[`ACFM_BIT_INPUT_MASK];
  assign ev_battery = (fault_rise[5] | fault_rise[4]) &
                      ~fault_irq_mask_q[`ACFM_BIT_BATTERY_MASK];
  assign ev_system = (fault_rise[3] | fault_rise[2]) &
                     ~fault_irq_mask_q[`ACFM_BIT_SYSTEM_MASK];
  assign ev_thermal = fault_rise[1] & ~fault_irq_mask_q[`ACFM_BIT_THERMAL_MASK];
  assign ev_zone = zone_change & ~fault_irq_mask_q[`ACFM_BIT_ZONE_MASK];
  assign ev_done = conv_finished & conv_single_shot & ~done_mask_q[`ACFM_BIT_DONE_MASK];

  // Events in the same cycle merge into one pulse; back to back events give a
  // stretched level, which a level-sensitive host cannot tell apart.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_pulse <= 1'b0;
    end else if (clk_en) begin
      irq_pulse <= ev_input | ev_battery | ev_system | ev_thermal | ev_zone | ev_done;
    end
  end

endmodule // acfm_top

`default_nettype wire

// ==== rtl/acfm_defs.vh ====
// Constants shared by the converter control and fault mask block.
`ifndef ACFM_DEFS_VH
`define ACFM_DEFS_VH

// ---------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ---------------------------------------------------------------
`define ACFM_IDX_FAULT_FLAG 6'h22
`define ACFM_IDX_DONE_MASK 6'h23
`define ACFM_IDX_FAULT_MASK 6'h25
`define ACFM_IDX_CONV_CTRL 6'h26
`define ACFM_IDX_CH_DISABLE 6'h27
`define ACFM_IDX_IIN_RESULT 6'h28

// ---------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------
`define ACFM_RST_FAULT_MASK 8'h00
`define ACFM_RST_CONV_CTRL 8'h30
`define ACFM_RST_CH_DISABLE 8'h00
`define ACFM_RST_DONE_MASK 8'h00
`define ACFM_RST_RESULT 15'h0000
`define ACFM_RST_CONV_EN 1'b0
`define ACFM_RST_SINGLE_SHOT 1'b0
`define ACFM_RST_RESOLUTION 2'h3
`define ACFM_RST_AVG_SEL 1'b0
`define ACFM_RST_SEED_SEL 1'b0

// ---------------------------------------------------------------
// Writable bit masks; reserved bits are zero here.
// ---------------------------------------------------------------
`define ACFM_WMASK_FAULT_MASK 8'hE9
`define ACFM_WMASK_CONV_CTRL 8'hFC
`define ACFM_WMASK_DONE_MASK 8'h40

// ---------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------
`define ACFM_BIT_INPUT_MASK 7
`define ACFM_BIT_BATTERY_MASK 6
`define ACFM_BIT_SYSTEM_MASK 5
`define ACFM_BIT_THERMAL_MASK 3
`define ACFM_BIT_ZONE_MASK 0
`define ACFM_BIT_CONV_EN 7
`define ACFM_BIT_SINGLE_SHOT 6
`define ACFM_BIT_RES_HI 5
`define ACFM_BIT_RES_LO 4
`define ACFM_BIT_AVG_SEL 3
`define ACFM_BIT_SEED_SEL 2
`define ACFM_BIT_DONE_MASK 6
`define ACFM_BIT_INPUT_FLAG 7
`define ACFM_BIT_IIN_CH_OFF 7

// ---------------------------------------------------------------
// Input current clamp limits, 2 mA per code, 15-bit field.
// ---------------------------------------------------------------
`define ACFM_IIN_MAX 16'sh07D0
`define ACFM_IIN_MIN (-16'sh07D0)

// ---------------------------------------------------------------
// Bus answer states.
// ---------------------------------------------------------------
`define ACFM_WAIT_BUSY 1'b1
`define ACFM_WAIT_DONE 1'b0

`endif

// ==== rtl/acfm_sync.v ====
// Two flip-flop level synchroniser for asynchronous status inputs.
`timescale 1ns/100ps
`default_nettype none

module acfm_sync #(
  parameter W = 1
) (
  // Clock, reset and enable.
  input wire ref_clk,
  input wire reset_n,
  input wire clk_en,
  // Asynchronous input and synchronised output.
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  // First stage, read only by the second stage.
  reg [W-1:0] meta_q;

  // ---------------------------------------------------------------
  // Synchroniser chain.
  // ---------------------------------------------------------------
  // Both stages hold while the clock enable is low.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // acfm_sync

`default_nettype wire

// ==== rtl/acfm_event.v ====
// Rising edge and change detector on synchronised status levels.
`timescale 1ns/100ps
`default_nettype none

module acfm_event #(
  parameter W = 1
) (
  // Clock, reset and enable.
  input wire ref_clk,
  input wire reset_n,
  input wire clk_en,
  // Synchronised level in.
  input wire [W-1:0] level_in,
  // Per-bit rising edge and any-bit change, combinational.
  output wire [W-1:0] rise,
  output wire change
);

  // Previous sample of the level.
  reg [W-1:0] prev_q;

  // ---------------------------------------------------------------
  // History register.
  // ---------------------------------------------------------------
  // Resets to zero, so a level already high after reset counts as an entry.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= {W{1'b0}};
    end else if (clk_en) begin
      prev_q <= level_in;
    end
  end

  assign rise = level_in & ~prev_q;
  assign change = |(level_in ^ prev_q);

endmodule // acfm_event

`default_nettype wire

// ==== bench/acfm_checker.sv ====
// Concurrent checks on the converter control and fault mask block.
`timescale 1ns/100ps
`default_nettype none

module acfm_checker (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register bus.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Fault levels and converter handshake.
  input wire logic [5:0] flt,
  input wire logic [2:0] temp_zone_in,
  input wire logic conv_done,
  // Settings and interrupt.
  input wire logic conv_enable,
  input wire logic conv_single_shot,
  input wire logic [1:0] conv_resolution,
  input wire logic running_average_sel,
  input wire logic average_seed_sel,
  input wire logic [7:0] conv_channel_off,
  input wire logic irq_pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // -------------------------------------------------------------
  // Cause history: a pulse needs an input change or a done within six cycles.
  // -------------------------------------------------------------
  logic [8:0] lvl_q;
  logic [5:0] hist_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lvl_q <= 9'h000;
      hist_q <= 6'h00;
    end else begin
      lvl_q <= {flt, temp_zone_in};
      hist_q <= {hist_q[4:0], ({flt, temp_zone_in} != lvl_q) || conv_done};
    end
  end
  // A write also covers the case where the ctrl register is the target.
  wire acc_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  // -------------------------------------------------------------
  // Assertions.
  // -------------------------------------------------------------
  chk_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_reset_vals: assert property ($rose(reset_n) |-> !conv_enable && conv_resolution == 2'h3)
    else $error("settings wrong after reset");
  chk_single_clear: assert property (conv_done && conv_enable && conv_single_shot && !avs_write
    |=> !conv_enable)
    else $error("single shot left converter enabled");
  chk_irq_cause: assert property (irq_pulse |-> |hist_q)
    else $error("interrupt pulse without a cause");
  chk_ctrl_write: assert property (acc_wr && avs_address == 8'h98 |=> conv_enable == $past(avs_writedata[7])
    && conv_resolution == $past(avs_writedata[5:4]) && average_seed_sel == $past(avs_writedata[2]))
    else $error("ctrl write not applied");
  chk_chan_write: assert property (acc_wr && avs_address == 8'h9C |=> conv_channel_off == $past(avs_writedata[7:0]))
    else $error("channel disable write not applied");
  chk_ctrl_hold: assert property (!avs_write |=> $stable({conv_single_shot, conv_resolution,
    running_average_sel, average_seed_sel, conv_channel_off}))
    else $error("settings changed without a write");
  chk_write_rdata: assert property (avs_write && !avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data not zero on write answer");
  chk_unmapped_rd: assert property (avs_read && !avs_waitrequest && avs_address[7:2] == 6'h00
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // Main scenarios.
  cov_irq: cover property (irq_pulse);
  cov_single: cover property (conv_done && conv_single_shot && conv_enable);
  cov_result_rd: cover property (avs_read && !avs_waitrequest && avs_address == 8'hA0);
endmodule // acfm_checker

bind acfm_top acfm_checker acfm_checker_i (.ref_clk(ref_clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .flt({thermal_shutdown_in, system_short_in, system_ovp_in, battery_ovp_in, battery_ocp_in,
  input_fault_in}), .temp_zone_in(temp_zone_in), .conv_done(conv_done),
  .conv_enable(conv_enable), .conv_single_shot(conv_single_shot),
  .conv_resolution(conv_resolution), .running_average_sel(running_average_sel),
  .average_seed_sel(average_seed_sel), .conv_channel_off(conv_channel_off),
  .irq_pulse(irq_pulse));
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the converter control and fault mask block.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  // -------------------------------------------------------------
  // Stimulus and observed signals.
  // -------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] wdata = 32'h0;
  logic [5:0] flt = 6'h00;
  logic [2:0] zone = 3'h0;
  logic done = 1'b0;
  logic [15:0] raw = 16'h0000;
  logic [31:0] rdata;
  logic wait_r, en, ss, avg, seed, irq;
  logic [1:0] res;
  logic [7:0] choff;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  int pulses;
  logic [31:0] rv;

  // Clock enable stays high; freezing is not exercised here.
  acfm_top acfm_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_byteenable(be),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_r),
    .input_fault_in(flt[0]), .battery_ocp_in(flt[1]), .battery_ovp_in(flt[2]),
    .system_ovp_in(flt[3]), .system_short_in(flt[4]), .thermal_shutdown_in(flt[5]),
    .temp_zone_in(zone), .conv_done(done), .conv_iin_raw(raw), .conv_enable(en),
    .conv_single_shot(ss), .conv_resolution(res), .running_average_sel(avg),
    .average_seed_sel(seed), .conv_channel_off(choff), .irq_pulse(irq));

  // 40 MHz clock.
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // The whole run takes a few hundred cycles; far beyond that is a hang.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("mismatch at %0t: run timed out", $time);
      results();
    end
  end

  // -------------------------------------------------------------
  // Shared tasks.
  // -------------------------------------------------------------
  task automatic results();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access; held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wait_r !== 1'b0 && n < 20);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 20) begin
      check(1'b0, 1'b1);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rv, exp);
  endtask

  // Counts interrupt pulses over n cycles.
  task automatic watch(input int n);
    pulses = 0;
    repeat (n) begin
      @(posedge ref_clk);
      if (irq === 1'b1) pulses++;
    end
  endtask

  // One-cycle conversion done carrying a raw sample.
  task automatic conv(input logic [15:0] v);
    @(posedge ref_clk);
    done <= 1'b1;
    raw <= v;
    @(posedge ref_clk);
    done <= 1'b0;
    watch(4);
  endtask

  // Continuous conversion: no pulse, result field placed in bits 15:1.
  task automatic conv_chk(input logic [15:0] v, input logic [31:0] exp);
    conv(v);
    check(pulses, 0);
    rd_chk(8'hA0, exp);
  endtask

  // Raises one fault source with its mask set or clear and counts pulses.
  task automatic irq_case(input int i, input logic m, input int exp);
    int b;
    b = (i == 0) ? 7 : (i < 3) ? 6 : (i < 5) ? 5 : (i == 5) ? 3 : 0;
    wr_reg(8'h94, m ? (32'h1 << b) : 32'h0);
    @(posedge ref_clk);
    if (i < 6) flt <= flt | (6'h01 << i);
    else zone <= zone ^ 3'h1;
    watch(8);
    check(pulses, exp);
    flt <= 6'h00;
    watch(8);
  endtask

  // -------------------------------------------------------------
  // Scenarios.
  // -------------------------------------------------------------
  task automatic t_reset();
    check({en, ss, res, avg, seed, choff, irq}, 32'h1800);
    rd_chk(8'h94, 32'h0);
    rd_chk(8'h98, 32'h30);
    rd_chk(8'h9C, 32'h0);
    rd_chk(8'hA0, 32'h0);
    rd_chk(8'h00, 32'h0);
  endtask

  task automatic t_reserved();
    wr_reg(8'h94, 32'hFF);
    rd_chk(8'h94, 32'hE9);
    wr_reg(8'h98, 32'hFF);
    rd_chk(8'h98, 32'hFC);
    check({en, ss, res, avg, seed}, 32'h3F);
    wr_reg(8'h98, 32'h30);
    wr_reg(8'hA0, 32'hFFFF);
    rd_chk(8'hA0, 32'h0);
    be <= 4'hE;
    wr_reg(8'h9C, 32'hFF);
    be <= 4'hF;
    rd_chk(8'h9C, 32'h0);
    wr_reg(8'h9C, 32'hA5);
    @(posedge ref_clk);
    check(choff, 32'hA5);
    wr_reg(8'h9C, 32'h0);
  endtask

  task automatic t_irq();
    for (int i = 0; i < 7; i++) irq_case(i, 1'b1, 0);
    rd_chk(8'h88, 32'h80);
    rd_chk(8'h88, 32'h0);
    for (int i = 0; i < 7; i++) irq_case(i, 1'b0, 1);
    @(posedge ref_clk);
    flt <= 6'h3F;
    zone <= zone ^ 3'h1;
    watch(8);
    check(pulses, 1);
    flt <= 6'h00;
    watch(8);
  endtask

  task automatic t_convert();
    conv(16'h0064);
    rd_chk(8'hA0, 32'h0);
    wr_reg(8'h98, 32'h80);
    conv_chk(16'h0064, 32'h00C8);
    conv_chk(16'h0BB8, 32'h0FA0);
    conv_chk(16'h07D0, 32'h0FA0);
    conv_chk(16'hF448, 32'hF060);
    conv_chk(16'hF830, 32'hF060);
    conv_chk(16'hFFFF, 32'hFFFE);
    wr_reg(8'h9C, 32'h80);
    conv_chk(16'h0064, 32'hFFFE);
    wr_reg(8'h9C, 32'h7F);
    conv_chk(16'h0064, 32'h00C8);
    wr_reg(8'h9C, 32'h0);
  endtask

  task automatic t_average();
    wr_reg(8'h98, 32'h8C);
    conv_chk(16'h0190, 32'h0320);
    conv_chk(16'h00C8, 32'h0258);
    wr_reg(8'h98, 32'h00);
    wr_reg(8'h98, 32'h88);
    conv_chk(16'h0064, 32'h0190);
  endtask

  task automatic t_single();
    for (int m = 0; m < 2; m++) begin
      wr_reg(8'h8C, m ? 32'h40 : 32'h0);
      wr_reg(8'h98, 32'hC0);
      conv(16'h000A);
      check(pulses, 1 - m);
      check(en, 32'h0);
      rd_chk(8'hA0, 32'h14);
    end
    rd_chk(8'h8C, 32'h40);
    conv(16'h0014);
    rd_chk(8'hA0, 32'h14);
  endtask

  // Main sequence.
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_reserved();
    t_irq();
    t_convert();
    t_average();
    t_single();
    results();
  end
endmodule // testbench
`default_nettype wire
